/* include/pqsr_regs.vh */
// Purpose: offsets, field positions and reset values of the power quality status bank
// Assumes: word-indexed register port, 24-bit data fields in 32-bit words
// Notes:   offsets are register indices on the device's own register port
`ifndef PQSR_REGS_VH
`define PQSR_REGS_VH

`define PQSR_ADDR_W            12
`define PQSR_DIP_THR_ADDR      12'h410
`define PQSR_DIP_A_ADDR        12'h411
`define PQSR_DIP_B_ADDR        12'h412
`define PQSR_DIP_C_ADDR        12'h413
`define PQSR_SWELL_THR_ADDR    12'h414
`define PQSR_SWELL_A_ADDR      12'h415
`define PQSR_SWELL_B_ADDR      12'h416
`define PQSR_SWELL_C_ADDR      12'h417
`define PQSR_NOLOAD_ADDR       12'h41F
`define PQSR_REDIRECT_ADDR     12'h424

`define PQSR_VAL_W             24
`define PQSR_DIP_THR_RST       24'h000000
`define PQSR_DIP_VAL_RST       24'h7FFFFF
`define PQSR_SWELL_THR_RST     24'hFFFFFF
`define PQSR_SWELL_VAL_RST     24'h000000

`define PQSR_NOLOAD_W          18
`define PQSR_NOLOAD_RST        18'h00000
`define PQSR_NL_A_LSB          0
`define PQSR_NL_B_LSB          6
`define PQSR_NL_C_LSB          12

`define PQSR_REDIR_W           21
`define PQSR_REDIR_RST         21'h1FFFFF
`define PQSR_SEL_KEEP          3'h7
`define PQSR_VC_SEL_LSB        18
`define PQSR_VB_SEL_LSB        15
`define PQSR_VA_SEL_LSB        12
`define PQSR_IN_SEL_LSB        9
`define PQSR_IC_SEL_LSB        6
`define PQSR_IB_SEL_LSB        3
`define PQSR_IA_SEL_LSB        0
`define PQSR_SEL_W             3

`define PQSR_CH_IA             3'h0
`define PQSR_CH_IB             3'h1
`define PQSR_CH_IC             3'h2
`define PQSR_CH_IN             3'h3
`define PQSR_CH_VA             3'h4
`define PQSR_CH_VB             3'h5
`define PQSR_CH_VC             3'h6

`endif

/* logic/pqsr_bank.v */
// Purpose: power quality status register bank with converter input redirection
// Assumes: one clock, synchronous active-low reset, single-cycle register port
// Notes:   capture strobes come from the half-cycle rms detectors outside this block
//
// Notes on behaviour
// [R1] dip threshold: 24-bit read/write, resets to zero.
// [R2] dip captures per phase: read-only 24-bit, reset 0x7FFFFF.
// [R3] swell threshold: 24-bit read/write, resets to all ones.
// [R4] swell captures per phase: read-only 24-bit, reset zero.
// [R5] phase A no-load flags in status bits 0..5, fixed energy order.
// [R6] phase B no-load flags in bits 6..11, same order as phase A.
// [R7] phase C no-load flags in bits 12,14..17; all flags reset zero.
// [R8] bit 13 flags phase C total reactive no-load.
// [R9] voltage C source select at bits 20:18, reset 7, 7 keeps VC.
// [R10] other six selectors share encoding, reset 7, 7 keeps own channel.
// [R11] reserved bits read zero; writes to read-only fields ignored.
`include "pqsr_regs.vh"
`default_nettype none

module pqsr_bank
(
	input  wire                      ref_clk_in,
	input  wire                      rst_n_in,
	// register port
	input  wire [`PQSR_ADDR_W-1:0]   reg_addr_in,
	input  wire                      reg_wr_in,
	input  wire                      reg_rd_in,
	input  wire [31:0]               reg_wdata_in,
	output reg  [31:0]               reg_rdata_out,
	// half-cycle rms captures
	input  wire [3*`PQSR_VAL_W-1:0]  dip_capture_in,
	input  wire [2:0]                dip_capture_stb_in,
	input  wire [3*`PQSR_VAL_W-1:0]  swell_capture_in,
	input  wire [2:0]                swell_capture_stb_in,
	// no-load levels from the energy accumulators, bit order as status register
	input  wire [`PQSR_NOLOAD_W-1:0] noload_flags_in,
	// converter samples, order IA IB IC IN VA VB VC (low to high)
	input  wire [7*`PQSR_VAL_W-1:0]  adc_data_in,
	// thresholds to the detectors
	output wire [`PQSR_VAL_W-1:0]    dip_threshold_value_out,
	output wire [`PQSR_VAL_W-1:0]    swell_threshold_value_out,
	// redirected datapath inputs, same order as adc_data_in
	output reg  [7*`PQSR_VAL_W-1:0]  datapath_data_out
);

	////////////////////////////////////////////////////////////////////////
	// storage
	reg  [`PQSR_VAL_W-1:0]    dip_thr_q;
	reg  [`PQSR_VAL_W-1:0]    swell_thr_q;
	reg  [3*`PQSR_VAL_W-1:0]  dip_cap_q;
	reg  [3*`PQSR_VAL_W-1:0]  swell_cap_q;
	reg  [`PQSR_NOLOAD_W-1:0] noload_q;
	reg  [`PQSR_REDIR_W-1:0]  redirect_q;
	reg  [31:0]               rdata_d;
	integer                   ph;
	genvar                    slot;

	// no-load flags by name, one wire per status bit
	// phase A
	wire                      phase_a_total_active_noload;
	wire                      phase_a_total_reactive_noload;
	wire                      phase_a_total_apparent_noload;
	wire                      phase_a_fund_active_noload;
	wire                      phase_a_fund_reactive_noload;
	wire                      phase_a_fund_apparent_noload;
	// phase B
	wire                      phase_b_total_active_noload;
	wire                      phase_b_total_reactive_noload;
	wire                      phase_b_total_apparent_noload;
	wire                      phase_b_fund_active_noload;
	wire                      phase_b_fund_reactive_noload;
	wire                      phase_b_fund_apparent_noload;
	// phase C
	wire                      phase_c_total_active_noload;
	wire                      phase_c_total_reactive_noload;
	wire                      phase_c_total_apparent_noload;
	wire                      phase_c_fund_active_noload;
	wire                      phase_c_fund_reactive_noload;
	wire                      phase_c_fund_apparent_noload;
	wire [31:0]               noload_word;

	// selector fields by name, three bits each
	// current inputs
	wire [2:0]                current_a_source_select;
	wire [2:0]                current_b_source_select;
	wire [2:0]                current_c_source_select;
	wire [2:0]                current_n_source_select;
	// voltage inputs
	wire [2:0]                voltage_a_source_select;
	wire [2:0]                voltage_b_source_select;
	wire [2:0]                voltage_c_source_select;
	// selectors packed in slot order, next datapath samples
	wire [7*`PQSR_SEL_W-1:0]  source_select;
	wire [7*`PQSR_VAL_W-1:0]  datapath_d;

	assign dip_threshold_value_out   = dip_thr_q;
	assign swell_threshold_value_out = swell_thr_q;

	////////////////////////////////////////////////////////////////////////
	// writable registers; only the field bits are stored
	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			// [R1] dip threshold reset
			dip_thr_q   <= `PQSR_DIP_THR_RST;
			// [R3] swell threshold reset
			swell_thr_q <= `PQSR_SWELL_THR_RST;
			// [R9] [R10] selectors reset keep
			redirect_q  <= `PQSR_REDIR_RST;
		end
		else if (reg_wr_in)
		begin
			// [R11] reserved bits dropped
			// read-only and unmapped indices fall to default and change nothing
			case (reg_addr_in)
				`PQSR_DIP_THR_ADDR:   dip_thr_q   <= reg_wdata_in[`PQSR_VAL_W-1:0];
				`PQSR_SWELL_THR_ADDR: swell_thr_q <= reg_wdata_in[`PQSR_VAL_W-1:0];
				`PQSR_REDIRECT_ADDR:  redirect_q  <= reg_wdata_in[`PQSR_REDIR_W-1:0];
				default:              dip_thr_q   <= dip_thr_q;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// captured rms values; software writes never reach these
	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
		begin
			// [R2] dip captures reset high
			dip_cap_q   <= {3{`PQSR_DIP_VAL_RST}};
			// [R4] swell captures reset low
			swell_cap_q <= {3{`PQSR_SWELL_VAL_RST}};
		end
		else
		begin
			for (ph = 0; ph < 3; ph = ph + 1)
			begin
				// [R2] dip capture load
				if (dip_capture_stb_in[ph])
					dip_cap_q[ph*`PQSR_VAL_W +: `PQSR_VAL_W] <= dip_capture_in[ph*`PQSR_VAL_W +: `PQSR_VAL_W];
				// [R4] swell capture load
				if (swell_capture_stb_in[ph])
					swell_cap_q[ph*`PQSR_VAL_W +: `PQSR_VAL_W] <= swell_capture_in[ph*`PQSR_VAL_W +: `PQSR_VAL_W];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// no-load status follows the accumulators, one cycle late
	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			// [R7] flags reset zero
			noload_q <= `PQSR_NOLOAD_RST;
		else
		begin
			// [R5] phase A bits
			noload_q[`PQSR_NL_A_LSB +: 6] <= noload_flags_in[`PQSR_NL_A_LSB +: 6];
			// [R6] phase B bits
			noload_q[`PQSR_NL_B_LSB +: 6] <= noload_flags_in[`PQSR_NL_B_LSB +: 6];
			// [R7] [R8] phase C bits
			noload_q[`PQSR_NL_C_LSB +: 6] <= noload_flags_in[`PQSR_NL_C_LSB +: 6];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// named view of the status bits; every phase group keeps one energy order,
	// so software can mask a phase with a fixed stride of six bits
	// [R5] phase A names
	assign phase_a_total_active_noload   = noload_q[`PQSR_NL_A_LSB + 0];
	assign phase_a_total_reactive_noload = noload_q[`PQSR_NL_A_LSB + 1];
	assign phase_a_total_apparent_noload = noload_q[`PQSR_NL_A_LSB + 2];
	assign phase_a_fund_active_noload    = noload_q[`PQSR_NL_A_LSB + 3];
	assign phase_a_fund_reactive_noload  = noload_q[`PQSR_NL_A_LSB + 4];
	assign phase_a_fund_apparent_noload  = noload_q[`PQSR_NL_A_LSB + 5];

	// [R6] phase B names
	assign phase_b_total_active_noload   = noload_q[`PQSR_NL_B_LSB + 0];
	assign phase_b_total_reactive_noload = noload_q[`PQSR_NL_B_LSB + 1];
	assign phase_b_total_apparent_noload = noload_q[`PQSR_NL_B_LSB + 2];
	assign phase_b_fund_active_noload    = noload_q[`PQSR_NL_B_LSB + 3];
	assign phase_b_fund_reactive_noload  = noload_q[`PQSR_NL_B_LSB + 4];
	assign phase_b_fund_apparent_noload  = noload_q[`PQSR_NL_B_LSB + 5];

	// [R7] phase C names
	assign phase_c_total_active_noload   = noload_q[`PQSR_NL_C_LSB + 0];
	// [R8] bit 13 phase C reactive
	assign phase_c_total_reactive_noload = noload_q[`PQSR_NL_C_LSB + 1];
	// [R7] remaining phase C
	assign phase_c_total_apparent_noload = noload_q[`PQSR_NL_C_LSB + 2];
	assign phase_c_fund_active_noload    = noload_q[`PQSR_NL_C_LSB + 3];
	assign phase_c_fund_reactive_noload  = noload_q[`PQSR_NL_C_LSB + 4];
	assign phase_c_fund_apparent_noload  = noload_q[`PQSR_NL_C_LSB + 5];

	// [R11] status word, bits 31:18 zero
	assign noload_word = {14'h0000,
		// phase C, bits 17..12
		phase_c_fund_apparent_noload,
		phase_c_fund_reactive_noload,
		phase_c_fund_active_noload,
		phase_c_total_apparent_noload,
		phase_c_total_reactive_noload,
		phase_c_total_active_noload,
		// phase B, bits 11..6
		phase_b_fund_apparent_noload,
		phase_b_fund_reactive_noload,
		phase_b_fund_active_noload,
		phase_b_total_apparent_noload,
		phase_b_total_reactive_noload,
		phase_b_total_active_noload,
		// phase A, bits 5..0
		phase_a_fund_apparent_noload,
		phase_a_fund_reactive_noload,
		phase_a_fund_active_noload,
		phase_a_total_apparent_noload,
		phase_a_total_reactive_noload,
		phase_a_total_active_noload};

	////////////////////////////////////////////////////////////////////////
	// selector fields by name; source_select slot order matches adc_data_in
	// [R9] voltage C selector
	assign voltage_c_source_select = redirect_q[`PQSR_VC_SEL_LSB +: `PQSR_SEL_W];
	// [R10] remaining selectors
	assign voltage_b_source_select = redirect_q[`PQSR_VB_SEL_LSB +: `PQSR_SEL_W];
	assign voltage_a_source_select = redirect_q[`PQSR_VA_SEL_LSB +: `PQSR_SEL_W];
	assign current_n_source_select = redirect_q[`PQSR_IN_SEL_LSB +: `PQSR_SEL_W];
	assign current_c_source_select = redirect_q[`PQSR_IC_SEL_LSB +: `PQSR_SEL_W];
	assign current_b_source_select = redirect_q[`PQSR_IB_SEL_LSB +: `PQSR_SEL_W];
	assign current_a_source_select = redirect_q[`PQSR_IA_SEL_LSB +: `PQSR_SEL_W];
	assign source_select = {voltage_c_source_select, voltage_b_source_select, voltage_a_source_select,
		current_n_source_select, current_c_source_select, current_b_source_select, current_a_source_select};

	////////////////////////////////////////////////////////////////////////
	// read mux; zero-extended so reserved bits read zero
	always @*
	begin
		rdata_d = 32'h00000000;
		// [R11] reserved read zero
		case (reg_addr_in)
			`PQSR_DIP_THR_ADDR:   rdata_d = {8'h00, dip_thr_q};
			`PQSR_DIP_A_ADDR:     rdata_d = {8'h00, dip_cap_q[0*`PQSR_VAL_W +: `PQSR_VAL_W]};
			`PQSR_DIP_B_ADDR:     rdata_d = {8'h00, dip_cap_q[1*`PQSR_VAL_W +: `PQSR_VAL_W]};
			`PQSR_DIP_C_ADDR:     rdata_d = {8'h00, dip_cap_q[2*`PQSR_VAL_W +: `PQSR_VAL_W]};
			`PQSR_SWELL_THR_ADDR: rdata_d = {8'h00, swell_thr_q};
			`PQSR_SWELL_A_ADDR:   rdata_d = {8'h00, swell_cap_q[0*`PQSR_VAL_W +: `PQSR_VAL_W]};
			`PQSR_SWELL_B_ADDR:   rdata_d = {8'h00, swell_cap_q[1*`PQSR_VAL_W +: `PQSR_VAL_W]};
			`PQSR_SWELL_C_ADDR:   rdata_d = {8'h00, swell_cap_q[2*`PQSR_VAL_W +: `PQSR_VAL_W]};
			`PQSR_NOLOAD_ADDR:    rdata_d = noload_word;
			`PQSR_REDIRECT_ADDR:  rdata_d = {11'h000, redirect_q};
			default:              rdata_d = 32'h00000000;
		endcase
	end

	// read data registered; unmapped reads give zero
	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			reg_rdata_out <= 32'h00000000;
		else if (reg_rd_in)
			reg_rdata_out <= rdata_d;
	end

	////////////////////////////////////////////////////////////////////////
	// redirection: each datapath slot picks any converter, code 7 keeps its own.
	// a full 8-way mux per slot costs area but lets any slot copy any input;
	// code 7 everywhere after reset gives the straight-through path
	generate
		for (slot = 0; slot < 7; slot = slot + 1)
		begin : g_redirect
			reg  [`PQSR_VAL_W-1:0] pick_d;
			// [R9] [R10] decode source code
			always @*
			begin
				pick_d = adc_data_in[slot*`PQSR_VAL_W +: `PQSR_VAL_W];
				case (source_select[slot*`PQSR_SEL_W +: `PQSR_SEL_W])
					`PQSR_CH_IA:    pick_d = adc_data_in[0*`PQSR_VAL_W +: `PQSR_VAL_W];
					`PQSR_CH_IB:    pick_d = adc_data_in[1*`PQSR_VAL_W +: `PQSR_VAL_W];
					`PQSR_CH_IC:    pick_d = adc_data_in[2*`PQSR_VAL_W +: `PQSR_VAL_W];
					`PQSR_CH_IN:    pick_d = adc_data_in[3*`PQSR_VAL_W +: `PQSR_VAL_W];
					`PQSR_CH_VA:    pick_d = adc_data_in[4*`PQSR_VAL_W +: `PQSR_VAL_W];
					`PQSR_CH_VB:    pick_d = adc_data_in[5*`PQSR_VAL_W +: `PQSR_VAL_W];
					`PQSR_CH_VC:    pick_d = adc_data_in[6*`PQSR_VAL_W +: `PQSR_VAL_W];
					`PQSR_SEL_KEEP: pick_d = adc_data_in[slot*`PQSR_VAL_W +: `PQSR_VAL_W];
					default:        pick_d = adc_data_in[slot*`PQSR_VAL_W +: `PQSR_VAL_W];
				endcase
			end
			assign datapath_d[slot*`PQSR_VAL_W +: `PQSR_VAL_W] = pick_d;
		end
	endgenerate

	// registered so the sample path sees one clean cycle of latency per slot
	always @(posedge ref_clk_in)
	begin
		if (!rst_n_in)
			datapath_data_out <= {7*`PQSR_VAL_W{1'b0}};
		else
			datapath_data_out <= datapath_d;
	end

endmodule

`default_nettype wire

/* tb/pqsr_bank_props.sv */
// Purpose: concurrent checks on the register port of the status bank
// Assumes: one clock, synchronous active-low reset
// Notes:   only the writable thresholds and read framing are visible here
`default_nettype none
module pqsr_bank_props
(
	input wire        ref_clk_in,
	input wire        rst_n_in,
	input wire [11:0] reg_addr_in,
	input wire        reg_wr_in,
	input wire        reg_rd_in,
	input wire [31:0] reg_wdata_in,
	input wire [31:0] reg_rdata_out,
	input wire [23:0] dip_threshold_value_out,
	input wire [23:0] swell_threshold_value_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	// a write or read aimed at one threshold
	sequence s_wd; reg_wr_in && reg_addr_in == 12'h410; endsequence
	sequence s_ws; reg_wr_in && reg_addr_in == 12'h414; endsequence
	sequence s_rd; reg_rd_in && reg_addr_in == 12'h410; endsequence
	sequence s_rs; reg_rd_in && reg_addr_in == 12'h414; endsequence
	property p_dw; s_wd |=> dip_threshold_value_out == $past(reg_wdata_in[23:0]); endproperty
	property p_sw; s_ws |=> swell_threshold_value_out == $past(reg_wdata_in[23:0]); endproperty
	property p_dh; !(reg_wr_in && reg_addr_in == 12'h410) |=> $stable(dip_threshold_value_out); endproperty
	property p_sh; !(reg_wr_in && reg_addr_in == 12'h414) |=> $stable(swell_threshold_value_out); endproperty
	// a read sees the value from before a same-cycle write
	property p_rd; s_rd |=> reg_rdata_out == {8'h00, $past(dip_threshold_value_out)}; endproperty
	property p_rs; s_rs |=> reg_rdata_out == {8'h00, $past(swell_threshold_value_out)}; endproperty
	property p_rsv; reg_rd_in |=> reg_rdata_out[31:24] == 8'h00; endproperty
	property p_unm; reg_rd_in && reg_addr_in == 12'h418 |=> reg_rdata_out == 32'h0; endproperty
	a_dw: assert property (p_dw) else $error("dip threshold write lost");
	a_sw: assert property (p_sw) else $error("swell threshold write lost");
	a_dh: assert property (p_dh) else $error("dip threshold moved unasked");
	a_sh: assert property (p_sh) else $error("swell threshold moved unasked");
	a_rd: assert property (p_rd) else $error("dip threshold readback wrong");
	a_rs: assert property (p_rs) else $error("swell threshold readback wrong");
	a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind pqsr_bank pqsr_bank_props pqsr_bank_props_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
	.reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
	.reg_rdata_out(reg_rdata_out), .dip_threshold_value_out(dip_threshold_value_out),
	.swell_threshold_value_out(swell_threshold_value_out));
`default_nettype wire

/* tb/pqsr_bank_test.sv */
// Purpose: self-checking bench for the power quality status bank
// Assumes: reads answer one edge after the strobe
// Notes:   inputs move on the falling edge, away from sampling
`default_nettype none
module pqsr_bank_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic         ref_clk_in, rst_n_in, wr, rd;
	logic [11:0]  addr;
	logic [31:0]  wdata, rdata;
	logic [71:0]  dip_v, swell_v;
	logic [2:0]   dip_s, swell_s;
	logic [17:0]  nl;
	logic [167:0] adc, dp;
	int           n_errors, n_compared, k;
	// every index with its reset word; 0x418 is unmapped
	logic [11:0]  ad [11] = '{12'h410, 12'h411, 12'h412, 12'h413, 12'h414, 12'h415, 12'h416, 12'h417,
		12'h41F, 12'h424, 12'h418};
	logic [31:0]  rv [11] = '{32'h0, 32'h7FFFFF, 32'h7FFFFF, 32'h7FFFFF, 32'hFFFFFF, 32'h0, 32'h0, 32'h0,
		32'h0, 32'h1FFFFF, 32'h0};
	pqsr_bank pqsr_bank_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .dip_capture_in(dip_v),
		.dip_capture_stb_in(dip_s), .swell_capture_in(swell_v), .swell_capture_stb_in(swell_s),
		.noload_flags_in(nl), .adc_data_in(adc), .dip_threshold_value_out(), .swell_threshold_value_out(),
		.datapath_data_out(dp));
////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	// one-cycle strobes, held across the taking edge
	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		@(negedge ref_clk_in);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge ref_clk_in);
		wr = 1'b0;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		@(negedge ref_clk_in);
		addr = a;
		rd = 1'b1;
		@(negedge ref_clk_in);
		rd = 1'b0;
		chk(exp, rdata);
	endtask
	task automatic stop_test;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
////////////////////////////////////////////////////////////////////////////////
	// free-running clock
	initial
	begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	// watchdog: the run needs well under 1000 cycles
	initial
	begin
		#20us;
		n_errors++;
		stop_test();
	end
	// main sequence; distinct sample per converter slot
	initial
	begin
		{wr, rd, addr, wdata, dip_v, swell_v, dip_s, swell_s, nl} = '0;
		for (k = 0; k < 7; k++) adc[24 * k +: 24] = 24'h111111 * (k + 1);
		rst_n_in = 1'b0;
		repeat (6) @(negedge ref_clk_in);
		rst_n_in = 1'b1;
		for (k = 0; k < 11; k++) rd_chk(ad[k], rv[k]);
		for (k = 0; k < 11; k++) wr_reg(ad[k], 32'hFFFFFFFF);
		for (k = 0; k < 11; k++) rd_chk(ad[k], k == 0 ? 32'hFFFFFF : rv[k]);
		// strobe only some phases so the others must keep their value
		@(negedge ref_clk_in);
		dip_v = 72'hC0C0C0_B0B0B0_A0A0A0;
		swell_v = 72'hC1C1C1_B1B1B1_A1A1A1;
		dip_s = 3'b101;
		swell_s = 3'b010;
		@(negedge ref_clk_in);
		{dip_s, swell_s} = '0;
		for (k = 1; k < 8; k++) rd_chk(ad[k], k == 1 ? 32'hA0A0A0 : k == 3 ? 32'hC0C0C0 : k == 6 ? 32'hB1B1B1 : rv[k]);
		for (k = 0; k < 18; k++)
		begin
			nl = 18'h1 << k;
			rd_chk(12'h41F, 32'h1 << k);
		end
		// every voltage C source code, output one cycle after the register
		for (k = 0; k < 8; k++)
		begin
			wr_reg(12'h424, {11'h0, k[2:0], 18'h3FFFF});
			@(negedge ref_clk_in);
			chk({8'h00, adc[24 * (k == 7 ? 6 : k) +: 24]}, {8'h00, dp[144 +: 24]});
		end
		wr_reg(12'h424, 32'h1FFFFE);
		@(negedge ref_clk_in);
		chk({8'h00, adc[144 +: 24]}, {8'h00, dp[23:0]});
		chk({8'h00, adc[24 +: 24]}, {8'h00, dp[24 +: 24]});
		rd_chk(12'h424, 32'h1FFFFE);
		// thresholds with values unlike their reset words
		wr_reg(12'h410, 32'hFF123456);
		wr_reg(12'h414, 32'hAB654321);
		rd_chk(12'h410, 32'h123456);
		rd_chk(12'h414, 32'h654321);
		stop_test();
	end
endmodule
`default_nettype wire
